// [hw/mrs_cfg.svh]
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH

// register offsets
`define MRS_OFS_CTRL      8'h00
`define MRS_OFS_STATUS    8'h04
`define MRS_OFS_IRQ_STAT  8'h08
`define MRS_OFS_IRQ_CLR   8'h0c
`define MRS_OFS_IRQ_EN    8'h10
`define MRS_OFS_TX_DATA   8'h14

// control fields
`define MRS_CTRL_BRIDGE   0
`define MRS_CTRL_SLEEP    1
`define MRS_CTRL_RESET    2'h0

// status fields
`define MRS_ST_MODE_LSB   0
`define MRS_ST_MODE_MSB   2
`define MRS_ST_AUTOBAUD   3
`define MRS_ST_BRIDGE     4
`define MRS_ST_FLAG       5
`define MRS_ST_TX_BUSY    6
`define MRS_ST_SLEEP_OK   7
`define MRS_ST_OSC_SEEN   8

// event bits, shared by status, clear and enable
`define MRS_EV_MODE       0
`define MRS_EV_BR_EXIT    1
`define MRS_EV_SOCK       2
`define MRS_EV_TX_DONE    3
`define MRS_EV_TX_DROP    4
`define MRS_EV_W          5
`define MRS_IRQ_EN_RESET  5'h00

// timing
`define MRS_CLK_KHZ       250000
`define MRS_MODE_SELECT_N_HOLD_MS  5000
`define MRS_MON_BAUD      115200
`define MRS_SETTLE_CYC    2'h2

`endif

// [hw/mrs_mode_reset_status.sv]
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "mrs_cfg.svh"

// Summary of operation
// - select low five seconds enters monitor mode
// - shorter low hold requests automatic baud detection
// - select falling exits transparent bridge mode; a low force input brings it back a cycle later
// - hard reset low clears all logic except the select synchroniser and the read data register
// - monitor mode: dual pin carries serial tx
// - application mode: flag rises on new data
// - application mode: flag falls on host read
// - application mode: force input low selects bridge mode
// - sleep inhibit high prevents sleep
module mrs_mode_reset_status #(
   parameter int unsigned HOLD_CYCLES = `MRS_MODE_SELECT_N_HOLD_MS * `MRS_CLK_KHZ,
   parameter int unsigned BAUD_DIV    =
      (`MRS_CLK_KHZ * 1000) / `MRS_MON_BAUD
) (
   // clock and reset
   input  wire logic          mclk_i,
   input  wire logic          rstn_i,
   // strap and status pins
   input  wire logic          hard_reset_in_n_i,
   input  wire logic          mode_select_n_i,
   input  wire logic          force_bridge_n_i,
   input  wire logic          sleep_inhibit_i,
   input  wire logic          oscillator_in_i,
   // socket events from the application
   input  wire logic          socket_new_data_i,
   input  wire logic          socket_read_i,
   // register port
   input  wire logic [7:0]    reg_addr_i,
   input  wire logic [31:0]   reg_wdata_i,
   input  wire logic          reg_wr_i,
   input  wire logic          reg_rd_i,
   output logic [31:0]        reg_rdata_o,
   // status outputs
   output mrs_pkg::mrs_state_t mode_o,
   output logic               autobaud_o,
   output logic               bridge_mode_o,
   output logic               sleep_allowed_o,
   output logic               dual_pin_o,
   output logic               irq_o
);
   import mrs_pkg::*;

   localparam int HW = $clog2(HOLD_CYCLES + 1);

   initial begin
      if (HOLD_CYCLES < 4) $error("HOLD_CYCLES must be at least 4");
      if (BAUD_DIV < 2) $error("BAUD_DIV must be at least 2");
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   // mode and timing state
   mrs_state_t         state;
   logic [1:0]         settle_cnt;
   logic [HW-1:0]      hold_cnt;
   logic               autobaud;
   // pin synchronisers
   logic               mode_select_n_meta;
   logic               mode_select_n_s;
   logic               mode_select_n_d;
   logic               osc_meta;
   logic               osc_s;
   logic               osc_d;
   logic               osc_seen;
   // software state
   logic [1:0]         ctrl;
   logic [`MRS_EV_W-1:0] irq_stat;
   logic [`MRS_EV_W-1:0] irq_en;
   logic [`MRS_EV_W-1:0] ev;
   logic [`MRS_EV_W-1:0] clr_mask;
   logic [`MRS_EV_W-1:0] next_irq_stat;
   // data paths
   logic               sock_flag;
   logic               bridge_exit;
   logic               mode_done;
   logic               tx_start;
   logic               tx_drop;
   logic               tx_busy;
   logic               tx_done;
   logic               tx_line;
   logic               wr_tx;
   logic [31:0]        status_word;

   // the hard reset pin is taken as a synchronous clear so that a
   // glitch on it never reaches the asynchronous tree
   wire logic hclr = !hard_reset_in_n_i;

   // only the second and third stages are looked at; the first may go metastable
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_select_n_meta <= 1'b1;
         mode_select_n_s    <= 1'b1;
         mode_select_n_d    <= 1'b1;
      end else begin
         mode_select_n_meta <= mode_select_n_i;
         mode_select_n_s    <= mode_select_n_meta;
         mode_select_n_d    <= mode_select_n_s;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         osc_meta <= 1'b0;
         osc_s    <= 1'b0;
         osc_d    <= 1'b0;
         osc_seen <= 1'b0;
      end else if (hclr) begin
         osc_meta <= 1'b0;
         osc_s    <= 1'b0;
         osc_d    <= 1'b0;
         osc_seen <= 1'b0;
      end else begin
         osc_meta <= oscillator_in_i;
         osc_s    <= osc_meta;
         osc_d    <= osc_s;
         if (osc_s && !osc_d) osc_seen <= 1'b1;
      end
   end

   // power-up strap decode: time how long select stays low
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state      <= MRS_START;
         settle_cnt <= 2'h0;
         hold_cnt   <= '0;
         autobaud   <= 1'b0;
         mode_done  <= 1'b0;
      end else if (hclr) begin
         state      <= MRS_START;
         settle_cnt <= 2'h0;
         hold_cnt   <= '0;
         autobaud   <= 1'b0;
         mode_done  <= 1'b0;
      end else begin
         mode_done <= 1'b0;
         unique case (state)
            MRS_START: begin
               // wait out the synchroniser before trusting the pin
               if (settle_cnt == `MRS_SETTLE_CYC) begin
                  if (!mode_select_n_s) begin
                     state    <= MRS_TIMING;
                     hold_cnt <= HW'(`MRS_SETTLE_CYC) + HW'(1);
                  end else begin
                     state     <= MRS_APP;
                     mode_done <= 1'b1;
                  end
               end else begin
                  settle_cnt <= settle_cnt + 2'h1;
               end
            end
            MRS_TIMING: begin
               if (mode_select_n_s) begin
                  state     <= MRS_APP;
                  autobaud  <= 1'b1;
                  mode_done <= 1'b1;
               end else if (hold_cnt >= HW'(HOLD_CYCLES - 1)) begin
                  state     <= MRS_MONITOR;
                  mode_done <= 1'b1;
               end else begin
                  hold_cnt <= hold_cnt + HW'(1);
               end
            end
            MRS_APP: begin
               state <= MRS_APP;
            end
            MRS_MONITOR: begin
               state <= MRS_MONITOR;
            end
            default: begin
               state <= MRS_START;
            end
         endcase
      end
   end

   // a falling select in application mode drops the bridge request
   assign bridge_exit = (state == MRS_APP) && bridge_mode_o
                        && mode_select_n_d && !mode_select_n_s;

   // control register; the hardware exit beats a software write
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl <= `MRS_CTRL_RESET;
      end else if (hclr) begin
         ctrl <= `MRS_CTRL_RESET;
      end else begin
         if (reg_wr_i && hit(reg_addr_i, `MRS_OFS_CTRL)) begin
            ctrl <= reg_wdata_i[1:0];
         end
         if (bridge_exit) begin
            ctrl[`MRS_CTRL_BRIDGE] <= 1'b0;
         end
      end
   end

   // socket data flag: a new arrival wins over a read in the same cycle
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sock_flag <= 1'b0;
      end else if (hclr || state != MRS_APP) begin
         sock_flag <= 1'b0;
      end else if (socket_new_data_i) begin
         sock_flag <= 1'b1;
      end else if (socket_read_i) begin
         sock_flag <= 1'b0;
      end
   end

   // monitor transmitter; bytes written while it is busy are dropped
   assign wr_tx    = reg_wr_i && hit(reg_addr_i, `MRS_OFS_TX_DATA)
                     && (state == MRS_MONITOR);
   assign tx_start = wr_tx && !tx_busy;
   assign tx_drop  = wr_tx && tx_busy;

   mrs_serial_tx #(
      .BAUD_DIV (BAUD_DIV)
   ) u_tx (
      .mclk_i   (mclk_i),
      .rstn_i   (rstn_i),
      .clear_i  (hclr),
      .start_i  (tx_start),
      .data_i   (reg_wdata_i[7:0]),
      .busy_o   (tx_busy),
      .done_o   (tx_done),
      .tx_o     (tx_line)
   );

   // registered pin and mode outputs
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_o          <= MRS_START;
         autobaud_o      <= 1'b0;
         bridge_mode_o   <= 1'b0;
         sleep_allowed_o <= 1'b0;
         dual_pin_o      <= 1'b0;
      end else if (hclr) begin
         mode_o          <= MRS_START;
         autobaud_o      <= 1'b0;
         bridge_mode_o   <= 1'b0;
         sleep_allowed_o <= 1'b0;
         dual_pin_o      <= 1'b0;
      end else begin
         mode_o        <= state;
         autobaud_o    <= autobaud;
         bridge_mode_o <= (state == MRS_APP) && !bridge_exit
                          && (!force_bridge_n_i
                              || ctrl[`MRS_CTRL_BRIDGE]);
         sleep_allowed_o <= !sleep_inhibit_i
                            && ctrl[`MRS_CTRL_SLEEP];
         if (state == MRS_MONITOR) begin
            dual_pin_o <= tx_line;
         end else begin
            dual_pin_o <= sock_flag;
         end
      end
   end

   // interrupt events; a set in the clearing cycle survives
   always_comb begin
      ev                     = '0;
      ev[`MRS_EV_MODE]       = mode_done;
      ev[`MRS_EV_BR_EXIT]    = bridge_exit;
      ev[`MRS_EV_SOCK]       = (state == MRS_APP) && socket_new_data_i
                               && !sock_flag;
      ev[`MRS_EV_TX_DONE]    = tx_done;
      ev[`MRS_EV_TX_DROP]    = tx_drop;
      clr_mask               = '0;
      if (reg_wr_i && hit(reg_addr_i, `MRS_OFS_IRQ_CLR)) begin
         clr_mask = reg_wdata_i[`MRS_EV_W-1:0];
      end
      next_irq_stat = (irq_stat & ~clr_mask) | ev;
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_stat <= '0;
         irq_en   <= `MRS_IRQ_EN_RESET;
         irq_o    <= 1'b0;
      end else if (hclr) begin
         irq_stat <= '0;
         irq_en   <= `MRS_IRQ_EN_RESET;
         irq_o    <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         if (reg_wr_i && hit(reg_addr_i, `MRS_OFS_IRQ_EN)) begin
            irq_en <= reg_wdata_i[`MRS_EV_W-1:0];
         end
         irq_o <= |(next_irq_stat & irq_en);
      end
   end

   // status word
   always_comb begin
      status_word                           = '0;
      status_word[`MRS_ST_MODE_MSB:`MRS_ST_MODE_LSB] = state;
      status_word[`MRS_ST_AUTOBAUD]         = autobaud;
      status_word[`MRS_ST_BRIDGE]           = bridge_mode_o;
      status_word[`MRS_ST_FLAG]             = sock_flag;
      status_word[`MRS_ST_TX_BUSY]          = tx_busy;
      status_word[`MRS_ST_SLEEP_OK]         = sleep_allowed_o;
      status_word[`MRS_ST_OSC_SEEN]         = osc_seen;
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            `MRS_OFS_CTRL:     reg_rdata_o <= {30'h0, ctrl};
            `MRS_OFS_STATUS:   reg_rdata_o <= status_word;
            `MRS_OFS_IRQ_STAT: reg_rdata_o <= {27'h0, irq_stat};
            `MRS_OFS_IRQ_EN:   reg_rdata_o <= {27'h0, irq_en};
            default:           reg_rdata_o <= '0;
         endcase
      end else begin
         reg_rdata_o <= '0;
      end
   end
endmodule

// [hw/mrs_pkg.sv]
package mrs_pkg;
   typedef enum logic [2:0] {
      MRS_START   = 3'b000,
      MRS_TIMING  = 3'b001,
      MRS_APP     = 3'b010,
      MRS_MONITOR = 3'b011
   } mrs_state_t;

   typedef enum logic [1:0] {
      MRS_TX_IDLE  = 2'b00,
      MRS_TX_SHIFT = 2'b01
   } mrs_tx_state_t;
endpackage

// [hw/mrs_serial_tx.sv]
`timescale 1ns/10ps
module mrs_serial_tx #(
   parameter int unsigned BAUD_DIV = 2170
) (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rstn_i,
   input  wire logic       clear_i,
   // byte request
   input  wire logic       start_i,
   input  wire logic [7:0] data_i,
   // state and line
   output logic            busy_o,
   output logic            done_o,
   output logic            tx_o
);
   import mrs_pkg::*;

   localparam int DW = $clog2(BAUD_DIV + 1);

   initial begin
      if (BAUD_DIV < 2) $error("BAUD_DIV must be at least 2");
   end

   mrs_tx_state_t   state;
   logic [9:0]      frame;
   logic [3:0]      bits_left;
   logic [DW-1:0]   div_cnt;

   // 8n1 frame, lsb first; line idles high
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state     <= MRS_TX_IDLE;
         frame     <= 10'h3ff;
         bits_left <= 4'h0;
         div_cnt   <= '0;
         done_o    <= 1'b0;
      end else if (clear_i) begin
         state     <= MRS_TX_IDLE;
         frame     <= 10'h3ff;
         bits_left <= 4'h0;
         div_cnt   <= '0;
         done_o    <= 1'b0;
      end else begin
         done_o <= 1'b0;
         unique case (state)
            MRS_TX_IDLE: begin
               if (start_i) begin
                  frame     <= {1'b1, data_i, 1'b0};
                  bits_left <= 4'ha;
                  div_cnt   <= DW'(BAUD_DIV - 1);
                  state     <= MRS_TX_SHIFT;
               end
            end
            MRS_TX_SHIFT: begin
               if (div_cnt != '0) begin
                  div_cnt <= div_cnt - 1'b1;
               end else if (bits_left == 4'h1) begin
                  frame   <= 10'h3ff;
                  state   <= MRS_TX_IDLE;
                  done_o  <= 1'b1;
               end else begin
                  frame     <= {1'b1, frame[9:1]};
                  bits_left <= bits_left - 1'b1;
                  div_cnt   <= DW'(BAUD_DIV - 1);
               end
            end
         endcase
      end
   end

   assign tx_o   = frame[0];
   assign busy_o = (state == MRS_TX_SHIFT);
endmodule

// [tb/mrs_board_model.sv]
`timescale 1ns/10ps
module mrs_board_model #(
   parameter int RES_CYC = 40
) (
   // clock
   input  wire logic mclk_i,
   // reset request
   input  wire logic pulse_i,
   // board pins
   output logic      hard_reset_in_n_o,
   output logic      oscillator_o
);
   int cnt = 0;
   // free running, phase unrelated to the core clock
   initial begin
      oscillator_o = 1'b0;
      #7.3;
      forever #31.25 oscillator_o = ~oscillator_o;
   end
   // reset span scaled down from milliseconds to keep runs short
   always_ff @(posedge mclk_i) begin
      if (pulse_i) begin
         cnt <= RES_CYC;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
   assign hard_reset_in_n_o = (cnt == 0);
endmodule

// [tb/mrs_mode_reset_status_tb.sv]
`timescale 1ns/10ps
`include "mrs_cfg.svh"
module mrs_mode_reset_status_tb;
   import mrs_pkg::*;
   localparam int unsigned HOLD = 200;
   localparam int unsigned BDIV = 4;
   logic        mclk_i            = 1'b0;
   logic        rstn_i            = 1'b0;
   logic        hard_reset_in_n_i;
   logic        mode_select_n_i   = 1'b1;
   logic        force_bridge_n_i  = 1'b1;
   logic        sleep_inhibit_i   = 1'b0;
   logic        oscillator_in_i;
   logic        socket_new_data_i = 1'b0;
   logic        socket_read_i     = 1'b0;
   logic [7:0]  reg_addr_i        = 8'h00;
   logic [31:0] reg_wdata_i       = 32'h0;
   logic        reg_wr_i          = 1'b0;
   logic        reg_rd_i          = 1'b0;
   logic        res_pulse         = 1'b0;
   logic [31:0] reg_rdata_o;
   mrs_state_t  mode_o;
   logic        autobaud_o;
   logic        bridge_mode_o;
   logic        sleep_allowed_o;
   logic        dual_pin_o;
   logic        irq_o;
   logic [31:0] rv;
   int          err_count         = 0;
   int          checks_done       = 0;

   mrs_mode_reset_status #(.HOLD_CYCLES(HOLD), .BAUD_DIV(BDIV)) dut_u (
      .mclk_i, .rstn_i, .hard_reset_in_n_i, .mode_select_n_i,
      .force_bridge_n_i, .sleep_inhibit_i, .oscillator_in_i,
      .socket_new_data_i, .socket_read_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .mode_o, .autobaud_o,
      .bridge_mode_o, .sleep_allowed_o, .dual_pin_o, .irq_o);
   mrs_board_model board_u (
      .mclk_i, .pulse_i(res_pulse), .hard_reset_in_n_o(hard_reset_in_n_i),
      .oscillator_o(oscillator_in_i));

   initial begin
      forever #2 mclk_i = ~mclk_i;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // strobe dropped with a spare edge so calls never collide
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      cyc(1);
      reg_wr_i    <= 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      cyc(1);
      reg_rd_i   <= 1'b0;
      // data stand for one cycle only; take them mid-cycle, then realign
      @(negedge mclk_i);
      d = reg_rdata_o;
      cyc(1);
   endtask
   task automatic rst(input logic sel);
      mode_select_n_i <= sel;
      rstn_i          <= 1'b0;
      cyc(3);
      rstn_i          <= 1'b1;
      cyc(1);
   endtask
   task automatic wait_mode(input mrs_state_t m);
      for (int i = 0; i < 400 && mode_o !== m; i++)
         @(posedge mclk_i);
      chk(32'(mode_o), 32'(m));
   endtask

   task automatic t_monitor;
      logic [9:0] bits;
      rst(1'b0);
      cyc(HOLD - 60);
      chk(32'(mode_o), 32'(MRS_TIMING));
      wait_mode(MRS_MONITOR);
      chk(32'(autobaud_o), 32'h0);
      chk(32'(dual_pin_o), 32'h1);
      wr(`MRS_OFS_TX_DATA, 32'ha5);
      for (int i = 0; i < 8 && dual_pin_o; i++)
         @(posedge mclk_i);
      cyc(BDIV / 2);
      for (int i = 0; i < 10; i++) begin
         bits[i] = dual_pin_o;
         cyc(BDIV);
      end
      chk(32'(bits), 32'h34a);
      cyc(2 * BDIV);
      wr(`MRS_OFS_TX_DATA, 32'h0f);
      wr(`MRS_OFS_TX_DATA, 32'h55);
      rd(`MRS_OFS_IRQ_STAT, rv);
      chk(rv, 32'h19);
      cyc(6);
      res_pulse <= 1'b1;
      cyc(1);
      res_pulse <= 1'b0;
      cyc(2);
      chk(32'(mode_o), 32'(MRS_START));
      chk(32'(dual_pin_o), 32'h0);
      mode_select_n_i <= 1'b1;
      wait_mode(MRS_APP);
      chk(32'(autobaud_o), 32'h0);
   endtask
   task automatic t_autobaud;
      rst(1'b0);
      cyc(50);
      mode_select_n_i <= 1'b1;
      wait_mode(MRS_APP);
      chk(32'(autobaud_o), 32'h1);
   endtask
   task automatic t_bridge;
      rst(1'b1);
      wait_mode(MRS_APP);
      rd(`MRS_OFS_IRQ_EN, rv);
      chk(rv, 32'h0);
      wr(`MRS_OFS_IRQ_EN, 32'h1f);
      wr(`MRS_OFS_IRQ_CLR, 32'h1f);
      wr(`MRS_OFS_CTRL, 32'h1);
      cyc(1);
      chk(32'(bridge_mode_o), 32'h1);
      mode_select_n_i <= 1'b0;
      cyc(6);
      chk(32'(bridge_mode_o), 32'h0);
      chk(32'(irq_o), 32'h1);
      rd(`MRS_OFS_IRQ_STAT, rv);
      chk(rv, 32'h2);
      rd(`MRS_OFS_CTRL, rv);
      chk(rv, 32'h0);
      wr(`MRS_OFS_IRQ_CLR, 32'h2);
      cyc(1);
      chk(32'(irq_o), 32'h0);
      mode_select_n_i  <= 1'b1;
      force_bridge_n_i <= 1'b0;
      cyc(8);
      chk(32'(bridge_mode_o), 32'h1);
      force_bridge_n_i <= 1'b1;
      cyc(3);
      chk(32'(bridge_mode_o), 32'h0);
      rd(8'h20, rv);
      chk(rv, 32'h0);
   endtask
   task automatic t_socket;
      socket_new_data_i <= 1'b1;
      cyc(1);
      socket_new_data_i <= 1'b0;
      cyc(3);
      chk(32'(dual_pin_o), 32'h1);
      rd(`MRS_OFS_IRQ_STAT, rv);
      chk(rv, 32'h4);
      chk(32'(irq_o), 32'h1);
      socket_new_data_i <= 1'b1;
      socket_read_i     <= 1'b1;
      cyc(1);
      socket_new_data_i <= 1'b0;
      socket_read_i     <= 1'b0;
      cyc(3);
      chk(32'(dual_pin_o), 32'h1);
      socket_read_i <= 1'b1;
      cyc(1);
      socket_read_i <= 1'b0;
      cyc(3);
      chk(32'(dual_pin_o), 32'h0);
   endtask
   task automatic t_sleep;
      wr(`MRS_OFS_CTRL, 32'h2);
      cyc(2);
      chk(32'(sleep_allowed_o), 32'h1);
      sleep_inhibit_i <= 1'b1;
      cyc(3);
      chk(32'(sleep_allowed_o), 32'h0);
      rd(`MRS_OFS_STATUS, rv);
      chk(rv, 32'h102);
   endtask

   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      cyc(1);
      t_monitor;
      t_autobaud;
      t_bridge;
      t_socket;
      t_sleep;
      conclude;
   end
   // whole run needs under 500 cycles
   initial begin
      cyc(20000);
      err_count++;
      conclude;
   end
endmodule

// [tb/mrs_monitor.sv]
`timescale 1ns/10ps
`include "mrs_cfg.svh"
module mrs_monitor #(
   parameter int unsigned HOLD_CYCLES = 200
) (
   // clock and reset
   input wire logic                mclk_i,
   input wire logic                rstn_i,
   // pins and strobes
   input wire logic                hard_reset_in_n_i,
   input wire logic                mode_select_n_i,
   input wire logic                force_bridge_n_i,
   input wire logic                sleep_inhibit_i,
   input wire logic                socket_new_data_i,
   input wire logic                socket_read_i,
   input wire logic [7:0]          reg_addr_i,
   input wire logic                reg_wr_i,
   // outputs watched
   input wire mrs_pkg::mrs_state_t mode_o,
   input wire logic                autobaud_o,
   input wire logic                bridge_mode_o,
   input wire logic                sleep_allowed_o,
   input wire logic                dual_pin_o
);
   import mrs_pkg::*;
   int unsigned up_cnt;
   // cycles since either reset let go; saturates so it never wraps
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         up_cnt <= 0;
      end else if (!hard_reset_in_n_i) begin
         up_cnt <= 0;
      end else if (up_cnt < 32'hffff) begin
         up_cnt <= up_cnt + 1;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   property p_mon;
      $rose(mode_o == MRS_MONITOR) |-> up_cnt + 8 >= HOLD_CYCLES
         && up_cnt <= HOLD_CYCLES + 8 && !$past(mode_select_n_i, 3);
   endproperty
   a_mon: assert property (p_mon)
      else $error("monitor entry off hold");
   property p_abd;
      $rose(autobaud_o) |-> mode_o == MRS_APP && up_cnt < HOLD_CYCLES;
   endproperty
   a_abd: assert property (p_abd)
      else $error("autobaud bad");
   property p_exit;
      $fell(mode_select_n_i) && bridge_mode_o && mode_o == MRS_APP
         && force_bridge_n_i |-> ##[1:4] !bridge_mode_o;
   endproperty
   a_exit: assert property (p_exit)
      else $error("bridge kept");
   property p_hrst;
      !hard_reset_in_n_i |=> mode_o == MRS_START && !bridge_mode_o
         && !autobaud_o && !dual_pin_o && !sleep_allowed_o;
   endproperty
   a_hrst: assert property (p_hrst)
      else $error("hard reset not clear");
   property p_tx;
      reg_wr_i && reg_addr_i == `MRS_OFS_TX_DATA && mode_o == MRS_MONITOR
         && dual_pin_o |-> ##[1:3] !dual_pin_o;
   endproperty
   a_tx: assert property (p_tx)
      else $error("no start bit");
   property p_set;
      mode_o == MRS_APP && socket_new_data_i |-> ##2 dual_pin_o;
   endproperty
   a_set: assert property (p_set)
      else $error("flag not raised");
   property p_clr;
      mode_o == MRS_APP && socket_read_i && !socket_new_data_i
         ##1 !socket_new_data_i |-> ##1 !dual_pin_o;
   endproperty
   a_clr: assert property (p_clr)
      else $error("flag not lowered");
   property p_frc;
      (mode_select_n_i && hard_reset_in_n_i && mode_o == MRS_APP
         && !force_bridge_n_i) [*5] |=> bridge_mode_o;
   endproperty
   a_frc: assert property (p_frc)
      else $error("force ignored");
   property p_slp;
      sleep_inhibit_i |=> !sleep_allowed_o;
   endproperty
   a_slp: assert property (p_slp)
      else $error("sleep not blocked");
endmodule

bind mrs_mode_reset_status mrs_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) mon_u (
   .mclk_i, .rstn_i, .hard_reset_in_n_i, .mode_select_n_i,
   .force_bridge_n_i, .sleep_inhibit_i, .socket_new_data_i,
   .socket_read_i, .reg_addr_i, .reg_wr_i, .mode_o, .autobaud_o,
   .bridge_mode_o, .sleep_allowed_o, .dual_pin_o);
